// >>> design/dsg_gate_ctrl.sv
// deep-sleep port clock gate and watchdog software reset control
// ****************************************
// Notes on behaviour
// - bits 4..0 of deep-sleep gate enable ports E..A during deep-sleep
// - access to a gated-off unit answers with a bus fault
// - gate and reset registers reset to all zeros
// - applied enables come from run, sleep or deep-sleep register per mode
// - sleep registers apply only while auto clock gating is selected
// - reserved bits are read-only and read as zero
// - bit 3 of software reset register is read/write watchdog reset control
// - software reset writes are masked by the capability register
// ****************************************
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
module dsg_gate_ctrl #(
   parameter int NUM_PORTS = 5
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire dsg_pkg::dsg_avm_req_t avmReq,
   output dsg_pkg::dsg_avm_rsp_t avmRsp,
   input wire dsg_pkg::dsg_power_mode_t powerMode,
   input wire logic auto_clock_gating_select,
   input wire logic [NUM_PORTS-1:0] run_port_clock_gate,
   input wire logic [NUM_PORTS-1:0] sleep_port_clock_gate,
   input wire logic [31:0] capability_mask_one,
   input wire logic [NUM_PORTS-1:0] portAccess,
   output logic [NUM_PORTS-1:0] portClockEnable,
   output logic [NUM_PORTS-1:0] portBusFault,
   output logic watchdogReset
);
   import dsg_pkg::*;

   // ****************************************
   // registers
   // ****************************************
   logic [NUM_PORTS-1:0] deep_sleep_port_clock_gate;
   logic watchdog_reset_bit;
   logic accessDone;

   // ****************************************
   // bus decode
   // ****************************************
   // one wait cycle, then complete; the done flag raises waitrequest again
   wire reqActive = avmReq.read | avmReq.write;
   wire accept = reqActive & ~accessDone;
   wire hitGate = avmReq.address == DEEP_SLEEP_PORT_CLOCK_GATE_OFS;
   wire hitReset = avmReq.address == SOFT_RESET_CTRL_0_OFS;
   wire mapped = hitGate | hitReset;
   wire doWrite = accept & avmReq.write & mapped;
   wire gateWrite = doWrite & hitGate & avmReq.byteenable[0];
   wire resetWrite = doWrite & hitReset & avmReq.byteenable[0];
   wire maskedWdog = capability_mask_one[WATCHDOG_RESET_BIT];
   wire [NUM_PORTS-1:0] next_gate = avmReq.writedata[NUM_PORTS-1:0];
   wire next_wdog = maskedWdog ? avmReq.writedata[WATCHDOG_RESET_BIT] : watchdog_reset_bit;
   logic [31:0] gateRead;
   logic [31:0] resetRead;
   always_comb begin
      gateRead = DEEP_SLEEP_PORT_CLOCK_GATE_RST;
      gateRead[NUM_PORTS-1:0] = deep_sleep_port_clock_gate;
      resetRead = SOFT_RESET_CTRL_0_RST;
      resetRead[WATCHDOG_RESET_BIT] = watchdog_reset_bit;
   end
   wire [31:0] next_readdata = hitGate ? gateRead : (hitReset ? resetRead : BUS_FAULT_DATA);
   wire [1:0] next_response = mapped ? AVM_RESP_OKAY : AVM_RESP_DECERR;

   // ****************************************
   // power mode decode
   // ****************************************
   // without auto gating the run register holds in every mode
   wire useSleepRegs = auto_clock_gating_select;
   wire modeRun = powerMode == DSG_RUN;
   wire modeSleep = powerMode == DSG_SLEEP;
   // the unused mode code falls through to deep-sleep, the lower-power choice
   wire modeDeep = !modeRun && !modeSleep;
   wire pickRun = !useSleepRegs || modeRun;
   wire pickSleep = useSleepRegs && modeSleep;
   wire pickDeep = useSleepRegs && modeDeep;

   // ****************************************
   // per-port gate selection and fault
   // ****************************************
   wire [NUM_PORTS-1:0] next_enable;
   wire [NUM_PORTS-1:0] next_fault;
   genvar port;
   generate
      for (port = 0; port < NUM_PORTS; port = port + 1) begin : g_port
         wire runBit = run_port_clock_gate[port];
         wire sleepBit = sleep_port_clock_gate[port];
         wire deepBit = deep_sleep_port_clock_gate[port];
         wire selRun = pickRun & runBit;
         wire selSleep = pickSleep & sleepBit;
         wire selDeep = pickDeep & deepBit;
         // a gated port cannot answer, so the access is refused here
         wire gatedOff = ~portClockEnable[port];
         assign next_enable[port] = selRun | selSleep | selDeep;
         assign next_fault[port] = portAccess[port] & gatedOff;
      end
   endgenerate

   // ****************************************
   // deep-sleep gate register
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         deep_sleep_port_clock_gate <= '0;
      end else if (gateWrite) begin
         deep_sleep_port_clock_gate <= next_gate;
      end
   end

   // ****************************************
   // software reset register
   // ****************************************
   // only the watchdog bit exists; the rest is reserved and never stored
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         watchdog_reset_bit <= 1'b0;
      end else if (resetWrite) begin
         watchdog_reset_bit <= next_wdog;
      end
   end

   // ****************************************
   // bus answer
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         accessDone <= 1'b0;
         avmRsp <= '{waitrequest: 1'b1, readdatavalid: 1'b0,
                     response: AVM_RESP_OKAY, readdata: '0};
      end else begin
         accessDone <= accept;
         avmRsp.waitrequest <= ~accept;
         avmRsp.readdatavalid <= accept & avmReq.read;
         if (accept) begin
            avmRsp.response <= next_response;
            avmRsp.readdata <= avmReq.read ? next_readdata : BUS_FAULT_DATA;
         end
      end
   end

   // ****************************************
   // outputs to gated units
   // ****************************************
   // applied enables lag the selection by one cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         portClockEnable <= '0;
      end else begin
         portClockEnable <= next_enable;
      end
   end

   // fault follows each refused access cycle one cycle later and stays high while the access is refused
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         portBusFault <= '0;
      end else begin
         portBusFault <= next_fault;
      end
   end

   // watchdog stays held while the control bit is set
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         watchdogReset <= 1'b0;
      end else begin
         watchdogReset <= watchdog_reset_bit;
      end
   end
endmodule : dsg_gate_ctrl

// >>> design/dsg_pkg.sv
// package: register map, field layout and carrier types for the deep-sleep gate block
package dsg_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [11:0] SOFT_RESET_CTRL_0_OFS = 12'h040;
   localparam logic [11:0] DEEP_SLEEP_PORT_CLOCK_GATE_OFS = 12'h128;
   localparam logic [31:0] SOFT_RESET_CTRL_0_RST = 32'h00000000;
   localparam logic [31:0] DEEP_SLEEP_PORT_CLOCK_GATE_RST = 32'h00000000;
   localparam logic [31:0] BUS_FAULT_DATA = 32'h00000000;

   // ****************************************
   // fields
   // ****************************************
   localparam int PORT_COUNT = 5;
   localparam int WATCHDOG_RESET_BIT = 3;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      DSG_RUN = 2'h0,
      DSG_SLEEP = 2'h1,
      DSG_DEEP = 2'h3
   } dsg_power_mode_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [11:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } dsg_avm_req_t;

   typedef struct packed {
      logic waitrequest;
      logic readdatavalid;
      logic [1:0] response;
      logic [31:0] readdata;
   } dsg_avm_rsp_t;

   localparam logic [1:0] AVM_RESP_OKAY = 2'h0;
   localparam logic [1:0] AVM_RESP_SLVERR = 2'h2;
   localparam logic [1:0] AVM_RESP_DECERR = 2'h3;
endpackage : dsg_pkg

// >>> sim/dsg_port_model.sv
// far-side model: gated ports that attempt bus accesses
`timescale 1ns/1ps
module dsg_port_model (
   input wire logic clk,
   input wire logic [4:0] pick,
   output logic [4:0] portAccess = '0
);
   always @(posedge clk) portAccess <= pick;
endmodule : dsg_port_model

// >>> sim/dsg_chk.sv
// assertions for the deep-sleep gate block
`timescale 1ns/1ps
module dsg_chk #(parameter int NUM_PORTS = 5) (
   input wire logic clk,
   input wire logic rst_b,
   input wire dsg_pkg::dsg_avm_req_t avmReq,
   input wire dsg_pkg::dsg_avm_rsp_t avmRsp,
   input wire logic [NUM_PORTS-1:0] portAccess,
   input wire logic [NUM_PORTS-1:0] portClockEnable,
   input wire logic [NUM_PORTS-1:0] portBusFault,
   input wire logic watchdogReset
);
   import dsg_pkg::*;
   wire done = !avmRsp.waitrequest;
   wire onWd = avmReq.address == SOFT_RESET_CTRL_0_OFS;
   wire mapped = onWd || avmReq.address == DEEP_SLEEP_PORT_CLOCK_GATE_OFS;
   wire wdWr = done && avmReq.write && onWd;
   wire [NUM_PORTS-1:0] hit = portAccess & ~portClockEnable;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   bus_fault_a: assert property ($past(rst_b) |-> portBusFault == $past(hit))
      else $error("bus fault wrong");
   wdog_change_a: assert property ($changed(watchdogReset) |-> $past(wdWr))
      else $error("watchdog changed unasked");
   wdog_read_a: assert property (done && avmReq.read && onWd |-> avmRsp.readdata[3] == watchdogReset)
      else $error("watchdog bit mismatch");
   reserved_zero_a: assert property (done && avmReq.read |-> avmRsp.readdata[31:5] == '0
      && !(onWd && |avmRsp.readdata[2:0])) else $error("reserved bits set");
   one_wait_a: assert property ($rose(avmReq.read || avmReq.write) |=> done)
      else $error("wait count wrong");
   wait_pulse_a: assert property (done |=> !done) else $error("waitrequest low too long");
   rdv_pulse_a: assert property (avmRsp.readdatavalid |-> done && avmReq.read)
      else $error("stray readdatavalid");
   resp_code_a: assert property (done |-> avmRsp.response == (mapped ? AVM_RESP_OKAY : AVM_RESP_DECERR))
      else $error("response code wrong");
   cover property (wdWr);
   cover property (|portBusFault);
   cover property (done && !mapped);
endmodule : dsg_chk
bind dsg_gate_ctrl dsg_chk #(.NUM_PORTS(NUM_PORTS)) chk (.*);

// >>> sim/test_dsg_gate_ctrl.sv
// self-checking bench for the deep-sleep gate block
`timescale 1ns/1ps
module test_dsg_gate_ctrl;
   import dsg_pkg::*;
   logic clk = 0, rst_b = 0, auto_clock_gating_select = 0, watchdogReset;
   logic [4:0] run_port_clock_gate = '0, sleep_port_clock_gate = '0, pick = '0, dsv = '0, gate;
   logic [4:0] portAccess, portClockEnable, portBusFault;
   logic [31:0] capability_mask_one = '0, rnd = 32'h2E, q[$];
   dsg_avm_req_t avmReq = '0;
   dsg_avm_rsp_t avmRsp;
   dsg_power_mode_t powerMode = DSG_RUN;
   int fail_count = 0, num_checks = 0, n;
   always #5 clk = ~clk;
   dsg_port_model far (.*);
   dsg_gate_ctrl dut (.*);
   task automatic check(string s, logic [31:0] seen, want);
      num_checks++;
      if (seen !== want) fail_count++;
      if (seen !== want) $display("CHECK FAILED %s expected %h seen %h", s, want, seen);
   endtask : check
   function automatic logic [31:0] xorshift(logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   task automatic close_out();
      $display("checks %0d failures %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   // reads note their data first; each request waits a whole edge after the last release so no signal is driven twice
   task automatic bus(logic w, logic [11:0] a, logic [31:0] d, e);
      if (!w) q.push_back(e);
      @(posedge clk) avmReq <= '{!w, w, a, 4'hF, d};
      for (n = 0; n < 50 && avmRsp.waitrequest !== 1'b0; n++) @(posedge clk);
      avmReq <= '0;
      if (n == 50) fail_count++;
      if (n == 50) close_out();
   endtask : bus
   always @(posedge clk)
      if (avmRsp.readdatavalid === 1'b1) check("readdata", avmRsp.readdata, q.pop_front());
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1;
      bus(0, 12'h040, 0, 0);
      bus(1, 12'h040, '1, 0);
      bus(0, 12'h040, 0, 0);
      capability_mask_one <= '1;
      bus(1, 12'h040, '1, 0);
      bus(0, 12'h040, 0, 32'h8);
      bus(0, 12'h044, 0, 0);
      check("watchdog", 32'(watchdogReset), 1);
      repeat (40) begin
         rnd = xorshift(rnd);
         bus(0, 12'h128, 0, 32'(dsv));
         bus(1, 12'h128, rnd, 0);
         dsv = rnd[4:0];
         powerMode <= dsg_power_mode_t'(rnd[2:1]);
         {auto_clock_gating_select, run_port_clock_gate, sleep_port_clock_gate, pick} <= rnd[18:3];
         repeat (2) @(posedge clk);
         gate = (!auto_clock_gating_select || powerMode == DSG_RUN) ? run_port_clock_gate
            : (powerMode == DSG_SLEEP) ? sleep_port_clock_gate : dsv;
         check("gate", 32'(portClockEnable), 32'(gate));
         @(posedge clk);
         check("fault", 32'(portBusFault), 32'(pick & ~gate));
      end
      close_out();
   end
endmodule : test_dsg_gate_ctrl
